// File: hdl/signal_option_pkg.sv
// Register map, field layout and serial-slave states for the signal option bank
`default_nettype none
package signal_option_pkg;
  // Register byte addresses
  localparam logic [7:0] ADDR_BAND_GAP = 8'h33;
  localparam logic [7:0] ADDR_MEDIAN = 8'h4C;
  localparam logic [7:0] ADDR_CONVERTER = 8'h4D;
  localparam logic [7:0] ADDR_SPC_FIRST = 8'h60;
  // Reset values
  localparam logic [7:0] RST_BAND_GAP = 8'h08;
  localparam logic [7:0] RST_MEDIAN = 8'h00;
  localparam logic [7:0] RST_CONVERTER = 8'h00;
  localparam logic [7:0] RST_SPC_FIRST = 8'h00;
  localparam logic [7:0] READ_UNMAPPED = 8'h00;
  // Band gap fields
  localparam int BG_EN_BIT = 7;
  localparam int BG_ADJ_MSB = 6;
  // Median filter option fields
  localparam int MED_AWB_BIT = 7;
  localparam int MED_RGB_BIT = 5;
  localparam int MED_YAUTO_BIT = 4;
  localparam int MED_YMAN_MSB = 2;
  // Converter option chroma delay field
  localparam int CONV_DLY_MSB = 3;
  localparam int CONV_DLY_LSB = 2;
  localparam logic [1:0] DLY_CODE_TWO = 2'h2;
  localparam logic [1:0] DLY_NONE = 2'h0;
  localparam logic [1:0] DLY_TWO_PIXELS = 2'h2;
  // Signal process control fields
  localparam int SPC_BOOST_BIT = 7;
  localparam int SPC_HALF_BIT = 6;
  localparam int SPC_GSW_RGB_BIT = 5;
  localparam int SPC_GSW_Y_BIT = 4;
  localparam int SPC_RED_MSB = 3;
  localparam int SPC_RED_LSB = 2;
  localparam int SPC_BLUE_MSB = 1;
  // Gain in tenths for each preamplifier code
  localparam logic [4:0] GAIN_X10 = 5'h0A;
  localparam logic [4:0] GAIN_X12 = 5'h0C;
  localparam logic [4:0] GAIN_X14 = 5'h0E;
  localparam logic [4:0] GAIN_X16 = 5'h10;
  // Serial slave
  localparam logic [2:0] LAST_BIT = 3'h7;
  localparam logic [6:0] DEFAULT_DEV_ADDR = 7'h2A; // Arbitrary value
  localparam logic [5:0] DEFAULT_GAIN_THRESH = 6'h20;
  typedef enum logic [8:0] {
    ST_IDLE = 9'h001,
    ST_DEV = 9'h002,
    ST_DEV_ACK = 9'h004,
    ST_SUB = 9'h008,
    ST_SUB_ACK = 9'h010,
    ST_WR = 9'h020,
    ST_WR_ACK = 9'h040,
    ST_RD = 9'h080,
    ST_RD_ACK = 9'h100
  } slave_state_e;
endpackage
`default_nettype wire

// File: hdl/camera_signal_option_regs.sv
// Signal option register bank with its two-wire serial control slave
//
// Overview of operation
// - Band gap register resets to 08; bit 7 enables, bits 6:0 adjust.
// - Median bit 7 scales white-balance step and range by one and a half.
// - Median bit 5 enables median filtering on the RGB path.
// - Median bit 4 switches luminance median filtering from the analog gain.
// - Median bits 2:0 manually enable luminance filtering for red, green, blue.
// - Chroma delay code 00 or 01 gives none, code 10 two pixel periods.
// - Control A bit 7 adds a 1.5x preamplifier gain.
// - Control A bit 6 selects half-current analog operation.
// - Control A bit 5 switches even/odd green in RGB and chroma paths.
// - Control A bit 4 switches even/odd green for luminance in YUV mode.
// - Red gain code 01, 10, 11 selects 1.2x, 1.4x, 1.6x.
// - Blue gain code 00 to 11 selects 1x, 1.2x, 1.4x, 1.6x.
// - Host reads and writes registers by byte address over two-wire serial.
`default_nettype none
module camera_signal_option_regs #(
  parameter logic [6:0] DEV_ADDR = signal_option_pkg::DEFAULT_DEV_ADDR,
  parameter logic [5:0] GAIN_THRESH = signal_option_pkg::DEFAULT_GAIN_THRESH
) (
  input wire logic sys_clk_i,
  input wire logic reset_n_i,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_o,
  input wire logic [5:0] analog_gain_i,
  input wire logic yuv_mode_i,
  output logic band_gap_en_o,
  output logic [6:0] band_gap_adj_o,
  output logic awb_scale_up_o,
  output logic rgb_median_en_o,
  output logic [2:0] y_median_en_o,
  output logic [1:0] chroma_delay_o,
  output logic preamp_boost_o,
  output logic half_current_o,
  output logic g_switch_rgb_uv_o,
  output logic g_switch_y_o,
  output logic [4:0] red_gain_o,
  output logic [4:0] blue_gain_o
);

  // Preamplifier code to gain in tenths; code 00 is unity for both channels
  function automatic logic [4:0] gain_tenths(input logic [1:0] code);
    unique case (code)
      2'h1: gain_tenths = signal_option_pkg::GAIN_X12;
      2'h2: gain_tenths = signal_option_pkg::GAIN_X14;
      2'h3: gain_tenths = signal_option_pkg::GAIN_X16;
      default: gain_tenths = signal_option_pkg::GAIN_X10;
    endcase
  endfunction

  // Pin synchronisers: three stages, filtered level moves when stages two and three agree
  logic [2:0] scl_sync, sda_sync;
  logic scl_f, sda_f, scl_p, sda_p;
  logic [2:0] next_scl_sync, next_sda_sync;
  logic next_scl_f, next_sda_f;

  always_comb begin
    next_scl_sync = {scl_sync[1:0], scl_i};
    next_sda_sync = {sda_sync[1:0], sda_i};
    next_scl_f = (scl_sync[2] == scl_sync[1]) ? scl_sync[2] : scl_f;
    next_sda_f = (sda_sync[2] == sda_sync[1]) ? sda_sync[2] : sda_f;
  end

  // Idle bus is high, so filters reset high to avoid a false start
  always_ff @(posedge sys_clk_i) begin
    if (!reset_n_i) begin
      scl_sync <= 3'h7;
      sda_sync <= 3'h7;
      scl_f <= 1'b1;
      sda_f <= 1'b1;
      scl_p <= 1'b1;
      sda_p <= 1'b1;
    end else begin
      scl_sync <= next_scl_sync;
      sda_sync <= next_sda_sync;
      scl_f <= next_scl_f;
      sda_f <= next_sda_f;
      scl_p <= scl_f;
      sda_p <= sda_f;
    end
  end

  // Bus events on the filtered levels
  logic scl_rise, scl_fall, bus_start, bus_stop;
  assign scl_rise = scl_f & ~scl_p;
  assign scl_fall = ~scl_f & scl_p;
  assign bus_start = scl_f & scl_p & sda_p & ~sda_f;
  assign bus_stop = scl_f & scl_p & ~sda_p & sda_f;

  // Register storage
  logic [7:0] band_gap_ref_ctrl, median_filter_option, converter_option_ctrl;
  logic [7:0] signal_process_ctrl_first;
  logic [7:0] next_band_gap_ref_ctrl, next_median_filter_option;
  logic [7:0] next_converter_option_ctrl, next_signal_process_ctrl_first;

  // Serial slave state
  signal_option_pkg::slave_state_e state, next_state;
  logic [2:0] bit_cnt, next_bit_cnt;
  logic [7:0] shifter, next_shifter;
  logic [7:0] sub_addr, next_sub_addr;
  logic ack_low, next_ack_low;
  logic read_dir, next_read_dir;
  logic sda_oe, next_sda_oe;
  logic [7:0] read_value;
  logic [7:0] wr_byte;

  // Read mux; unmapped addresses return zero
  always_comb begin
    unique case (sub_addr)
      signal_option_pkg::ADDR_BAND_GAP: read_value = band_gap_ref_ctrl;
      signal_option_pkg::ADDR_MEDIAN: read_value = median_filter_option;
      signal_option_pkg::ADDR_CONVERTER: read_value = converter_option_ctrl;
      signal_option_pkg::ADDR_SPC_FIRST: read_value = signal_process_ctrl_first;
      default: read_value = signal_option_pkg::READ_UNMAPPED;
    endcase
  end

  assign wr_byte = {shifter[6:0], sda_f};

  // Slave sequencing: device address, then sub-address and data write, or data read
  always_comb begin
    next_state = state;
    next_bit_cnt = bit_cnt;
    next_shifter = shifter;
    next_sub_addr = sub_addr;
    next_ack_low = ack_low;
    next_read_dir = read_dir;
    next_sda_oe = sda_oe;
    next_band_gap_ref_ctrl = band_gap_ref_ctrl;
    next_median_filter_option = median_filter_option;
    next_converter_option_ctrl = converter_option_ctrl;
    next_signal_process_ctrl_first = signal_process_ctrl_first;
    if (bus_start) begin
      next_state = signal_option_pkg::ST_DEV;
      next_bit_cnt = 3'h0;
      next_sda_oe = 1'b0;
      next_ack_low = 1'b0;
    end else if (bus_stop) begin
      next_state = signal_option_pkg::ST_IDLE;
      next_sda_oe = 1'b0;
      next_ack_low = 1'b0;
    end else begin
      unique case (state)
        signal_option_pkg::ST_DEV, signal_option_pkg::ST_SUB,
        signal_option_pkg::ST_WR: begin
          if (scl_rise) begin
            next_shifter = wr_byte;
            next_bit_cnt = bit_cnt + 3'h1;
            if (bit_cnt == signal_option_pkg::LAST_BIT) begin
              if (state == signal_option_pkg::ST_DEV) begin
                // Other devices on the bus are ignored until the next start
                next_read_dir = wr_byte[0];
                next_state = (wr_byte[7:1] == DEV_ADDR) ? signal_option_pkg::ST_DEV_ACK
                                                        : signal_option_pkg::ST_IDLE;
              end else if (state == signal_option_pkg::ST_SUB) begin
                next_sub_addr = wr_byte;
                next_state = signal_option_pkg::ST_SUB_ACK;
              end else begin
                // reserved bits stored, unmapped writes dropped
                unique case (sub_addr)
                  signal_option_pkg::ADDR_BAND_GAP: next_band_gap_ref_ctrl = wr_byte;
                  signal_option_pkg::ADDR_MEDIAN: next_median_filter_option = wr_byte;
                  signal_option_pkg::ADDR_CONVERTER: next_converter_option_ctrl = wr_byte;
                  signal_option_pkg::ADDR_SPC_FIRST: next_signal_process_ctrl_first = wr_byte;
                  default: next_sub_addr = sub_addr;
                endcase
                next_state = signal_option_pkg::ST_WR_ACK;
              end
            end
          end
        end
        signal_option_pkg::ST_DEV_ACK, signal_option_pkg::ST_SUB_ACK,
        signal_option_pkg::ST_WR_ACK: begin
          // First falling edge pulls data low, second releases it, or on a read after the device ack drives read data bit 7
          if (scl_fall) begin
            if (!ack_low) begin
              next_ack_low = 1'b1;
              next_sda_oe = 1'b1;
            end else begin
              next_ack_low = 1'b0;
              next_sda_oe = 1'b0;
              next_bit_cnt = 3'h0;
              if (state == signal_option_pkg::ST_DEV_ACK && read_dir) begin
                next_shifter = read_value;
                next_sda_oe = ~read_value[7];
                next_state = signal_option_pkg::ST_RD;
              end else if (state == signal_option_pkg::ST_DEV_ACK) begin
                next_state = signal_option_pkg::ST_SUB;
              end else begin
                next_state = signal_option_pkg::ST_WR;
              end
            end
          end
        end
        signal_option_pkg::ST_RD: begin
          if (scl_fall) begin
            next_shifter = {shifter[6:0], 1'b0};
            next_sda_oe = ~shifter[6];
          end
          if (scl_rise) begin
            next_bit_cnt = bit_cnt + 3'h1;
            if (bit_cnt == signal_option_pkg::LAST_BIT) begin
              next_state = signal_option_pkg::ST_RD_ACK;
            end
          end
        end
        signal_option_pkg::ST_RD_ACK: begin
          // Release for the host's acknowledge; one byte per read
          if (scl_fall) begin
            next_sda_oe = 1'b0;
          end
          if (scl_rise) begin
            next_state = signal_option_pkg::ST_IDLE;
          end
        end
        default: begin
          next_state = signal_option_pkg::ST_IDLE;
          next_sda_oe = 1'b0;
        end
      endcase
    end
  end

  // Slave and register flops
  always_ff @(posedge sys_clk_i) begin
    if (!reset_n_i) begin
      state <= signal_option_pkg::ST_IDLE;
      bit_cnt <= 3'h0;
      shifter <= 8'h00;
      sub_addr <= 8'h00;
      ack_low <= 1'b0;
      read_dir <= 1'b0;
      sda_oe <= 1'b0;
      band_gap_ref_ctrl <= signal_option_pkg::RST_BAND_GAP;
      median_filter_option <= signal_option_pkg::RST_MEDIAN;
      converter_option_ctrl <= signal_option_pkg::RST_CONVERTER;
      signal_process_ctrl_first <= signal_option_pkg::RST_SPC_FIRST;
    end else begin
      state <= next_state;
      bit_cnt <= next_bit_cnt;
      shifter <= next_shifter;
      sub_addr <= next_sub_addr;
      ack_low <= next_ack_low;
      read_dir <= next_read_dir;
      sda_oe <= next_sda_oe;
      band_gap_ref_ctrl <= next_band_gap_ref_ctrl;
      median_filter_option <= next_median_filter_option;
      converter_option_ctrl <= next_converter_option_ctrl;
      signal_process_ctrl_first <= next_signal_process_ctrl_first;
    end
  end

  // Decoded controls, registered so every output leaves a flip-flop
  logic next_band_gap_en, next_awb_scale_up, next_rgb_median_en, next_preamp_boost;
  logic next_half_current, next_g_switch_rgb_uv, next_g_switch_y, y_auto;
  logic [6:0] next_band_gap_adj;
  logic [2:0] next_y_median_en;
  logic [1:0] next_chroma_delay;
  logic [4:0] next_red_gain, next_blue_gain;

  always_comb begin
    next_band_gap_en = band_gap_ref_ctrl[signal_option_pkg::BG_EN_BIT];
    next_band_gap_adj = band_gap_ref_ctrl[signal_option_pkg::BG_ADJ_MSB:0];
    next_awb_scale_up = median_filter_option[signal_option_pkg::MED_AWB_BIT];
    next_rgb_median_en = median_filter_option[signal_option_pkg::MED_RGB_BIT];
    y_auto = median_filter_option[signal_option_pkg::MED_YAUTO_BIT]
             & (analog_gain_i >= GAIN_THRESH);
    next_y_median_en = median_filter_option[signal_option_pkg::MED_YMAN_MSB:0] | {3{y_auto}};
    next_chroma_delay = (converter_option_ctrl[signal_option_pkg::CONV_DLY_MSB:
                         signal_option_pkg::CONV_DLY_LSB] == signal_option_pkg::DLY_CODE_TWO)
                        ? signal_option_pkg::DLY_TWO_PIXELS : signal_option_pkg::DLY_NONE;
    next_preamp_boost = signal_process_ctrl_first[signal_option_pkg::SPC_BOOST_BIT];
    next_half_current = signal_process_ctrl_first[signal_option_pkg::SPC_HALF_BIT];
    next_g_switch_rgb_uv = signal_process_ctrl_first[signal_option_pkg::SPC_GSW_RGB_BIT];
    // green switch luminance, only in YUV mode
    next_g_switch_y = signal_process_ctrl_first[signal_option_pkg::SPC_GSW_Y_BIT] & yuv_mode_i;
    // red gain decode, code 00 unity
    next_red_gain = gain_tenths(signal_process_ctrl_first[signal_option_pkg::SPC_RED_MSB:
                                signal_option_pkg::SPC_RED_LSB]);
    next_blue_gain = gain_tenths(signal_process_ctrl_first[signal_option_pkg::SPC_BLUE_MSB:0]);
  end

  // Output flops
  always_ff @(posedge sys_clk_i) begin
    if (!reset_n_i) begin
      sda_o <= 1'b0; // Open drain: only ever pulls low
      sda_oe_o <= 1'b0;
      band_gap_en_o <= signal_option_pkg::RST_BAND_GAP[signal_option_pkg::BG_EN_BIT];
      band_gap_adj_o <= signal_option_pkg::RST_BAND_GAP[signal_option_pkg::BG_ADJ_MSB:0];
      awb_scale_up_o <= 1'b0;
      rgb_median_en_o <= 1'b0;
      y_median_en_o <= 3'h0;
      chroma_delay_o <= 2'h0;
      preamp_boost_o <= 1'b0;
      half_current_o <= 1'b0;
      g_switch_rgb_uv_o <= 1'b0;
      g_switch_y_o <= 1'b0;
      red_gain_o <= signal_option_pkg::GAIN_X10;
      blue_gain_o <= signal_option_pkg::GAIN_X10;
    end else begin
      sda_o <= 1'b0;
      sda_oe_o <= sda_oe;
      band_gap_en_o <= next_band_gap_en;
      band_gap_adj_o <= next_band_gap_adj;
      awb_scale_up_o <= next_awb_scale_up;
      rgb_median_en_o <= next_rgb_median_en;
      y_median_en_o <= next_y_median_en;
      chroma_delay_o <= next_chroma_delay;
      preamp_boost_o <= next_preamp_boost;
      half_current_o <= next_half_current;
      g_switch_rgb_uv_o <= next_g_switch_rgb_uv;
      g_switch_y_o <= next_g_switch_y;
      red_gain_o <= next_red_gain;
      blue_gain_o <= next_blue_gain;
    end
  end

endmodule
`default_nettype wire

// File: tb/signal_option_assertions.sv
// Port-level checker for the signal option register bank
`default_nettype none
module signal_option_checker #(
  parameter logic [6:0] DEV_ADDR = signal_option_pkg::DEFAULT_DEV_ADDR,
  parameter logic [5:0] GAIN_THRESH = signal_option_pkg::DEFAULT_GAIN_THRESH
) (
  input wire logic sys_clk_i,
  input wire logic reset_n_i,
  input wire logic scl_i,
  input wire logic sda_i,
  input wire logic sda_o,
  input wire logic sda_oe_o,
  input wire logic yuv_mode_i,
  input wire logic band_gap_en_o,
  input wire logic [6:0] band_gap_adj_o,
  input wire logic [1:0] chroma_delay_o,
  input wire logic g_switch_y_o,
  input wire logic [4:0] red_gain_o,
  input wire logic [4:0] blue_gain_o
);
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!reset_n_i);
  // Data rising while the clock is high only happens at a stop
  sequence stop_s;
    scl_i && $rose(sda_i);
  endsequence
  sequence ack_start_s;
    $rose(sda_oe_o);
  endsequence
  // Band gap adjust, red gain and chroma delay must not move for eight clocks once the host has closed a transfer
  sequence fields_hold_s;
    ($stable(band_gap_adj_o) && $stable(red_gain_o) && $stable(chroma_delay_o)) [*8];
  endsequence
  reset_values_a: assert property (
    $rose(reset_n_i) |-> band_gap_adj_o == 7'h08 && !band_gap_en_o && red_gain_o == 5'h0A
      && blue_gain_o == 5'h0A && !sda_oe_o) else $error("reset values wrong");
  drive_level_a: assert property (sda_o == 1'b0) else $error("data pin driven high");
  oe_scl_low_a: assert property (
    $changed(sda_oe_o) |-> !scl_i) else $error("data line moved while clock high");
  ack_hold_a: assert property (
    ack_start_s |=> sda_oe_o [*8]) else $error("drive too short");
  idle_stable_a: assert property (
    stop_s |=> fields_hold_s) else $error("field moved at idle");
  y_switch_gate_a: assert property (
    g_switch_y_o |-> $past(yuv_mode_i)) else $error("luma green switch outside YUV");
  delay_codes_a: assert property (
    chroma_delay_o == 2'h0 || chroma_delay_o == 2'h2) else $error("bad chroma delay");
  gain_codes_a: assert property (
    red_gain_o inside {5'h0A, 5'h0C, 5'h0E, 5'h10} && blue_gain_o inside {5'h0A, 5'h0C,
      5'h0E, 5'h10}) else $error("bad preamp gain");
endmodule

bind camera_signal_option_regs signal_option_checker #(.DEV_ADDR(DEV_ADDR),
  .GAIN_THRESH(GAIN_THRESH)) u_chk (.sys_clk_i(sys_clk_i), .reset_n_i(reset_n_i),
  .scl_i(scl_i), .sda_i(sda_i), .sda_o(sda_o), .sda_oe_o(sda_oe_o), .yuv_mode_i(yuv_mode_i),
  .band_gap_en_o(band_gap_en_o), .band_gap_adj_o(band_gap_adj_o),
  .chroma_delay_o(chroma_delay_o), .g_switch_y_o(g_switch_y_o), .red_gain_o(red_gain_o),
  .blue_gain_o(blue_gain_o));
`default_nettype wire

// File: tb/serial_host_model.sv
// Behavioural host controller on the two-wire control bus
`default_nettype none
module serial_host_model #(
  parameter int HALF = 12
) (
  input wire logic sys_clk_i,
  input wire logic dev_oe_i,
  input wire logic dev_dat_i,
  output logic scl_o,
  output logic sda_o
);
  logic pull_low = 1'b0;
  // Idle clock level held in one variable so the pin has a single driver
  logic scl_drv = 1'b1;
  assign scl_o = scl_drv;
  assign sda_o = !(pull_low || (dev_oe_i && !dev_dat_i)); // Pull-up when nobody drives
  task automatic wait_half();
    repeat (HALF) @(posedge sys_clk_i);
  endtask
  // Data moves a few clocks after the fall so the synchroniser never sees both move at once
  task automatic bit_io(input logic b, output logic r);
    repeat (3) @(posedge sys_clk_i);
    pull_low <= !b;
    wait_half();
    scl_drv <= 1'b1;
    wait_half();
    r = sda_o;
    scl_drv <= 1'b0;
  endtask
  task automatic start_cond();
    @(posedge sys_clk_i);
    pull_low <= 1'b1;
    wait_half();
    scl_drv <= 1'b0;
  endtask
  task automatic stop_cond();
    repeat (3) @(posedge sys_clk_i);
    pull_low <= 1'b1;
    wait_half();
    scl_drv <= 1'b1;
    wait_half();
    pull_low <= 1'b0;
    wait_half();
  endtask
  task automatic put_byte(input logic [7:0] b, output logic nack);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(b[i], r);
    bit_io(1'b1, nack);
  endtask
  task automatic write_reg(input logic [6:0] dev, input logic [7:0] sub,
                           input logic [7:0] data, output logic nack);
    logic n;
    start_cond();
    put_byte({dev, 1'b0}, nack);
    put_byte(sub, n);
    put_byte(data, n);
    stop_cond();
  endtask
  task automatic read_reg(input logic [6:0] dev, input logic [7:0] sub, output logic [7:0] data);
    logic n;
    start_cond();
    put_byte({dev, 1'b0}, n);
    put_byte(sub, n);
    stop_cond();
    start_cond();
    put_byte({dev, 1'b1}, n);
    for (int i = 7; i >= 0; i--) bit_io(1'b1, data[i]);
    bit_io(1'b1, n); // Not-acknowledge ends the read
    stop_cond();
  endtask
endmodule
`default_nettype wire

// File: tb/camera_signal_option_regs_tb_top.sv
// Self-checking bench for the signal option register bank
`default_nettype none
module camera_signal_option_regs_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [6:0] DEV = 7'h35; // Arbitrary value
  localparam logic [5:0] THRESH = 6'h20;
  localparam logic [28:0] RST_VEC = 29'h0100014A;
  typedef struct {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic [7:0] rdata;
    logic [28:0] outs;
  } row_s;
  // Cumulative expectations: each row builds on the state left by the one before
  row_s rows [11] = '{'{8'h33, 8'hFF, 8'hFF, 29'h1FE0014A}, '{8'h4C, 8'hB5, 8'hB5, 29'h1FFD014A},
    '{8'h4D, 8'hF8, 8'hF8, 29'h1FFD814A}, '{8'h60, 8'hF6, 8'hF6, 29'h1FFDBD8E},
    '{8'h4D, 8'h0C, 8'h0C, 29'h1FFD3D8E}, '{8'h4D, 8'h04, 8'h04, 29'h1FFD3D8E},
    '{8'h60, 8'h0B, 8'h0B, 29'h1FFD01D0}, '{8'h60, 8'h0D, 8'h0D, 29'h1FFD020C},
    '{8'h60, 8'h03, 8'h03, 29'h1FFD0150}, '{8'h50, 8'hAA, 8'h00, 29'h1FFD0150},
    '{8'h33, 8'h00, 8'h00, 29'h001D0150}};
  logic sys_clk = 1'b0;
  logic reset_n = 1'b0;
  logic [5:0] analog_gain = 6'h00;
  logic yuv_mode = 1'b1;
  logic nack;
  logic [7:0] rd;
  int n_errors = 0;
  int tests_run = 0;
  wire logic scl;
  wire logic sda;
  wire logic dat;
  wire logic oe;
  wire logic [28:0] out_vec;
  // Free-running 50 MHz clock
  always #10 sys_clk = ~sys_clk;
  camera_signal_option_regs #(.DEV_ADDR(DEV), .GAIN_THRESH(THRESH)) u_dut (
    .sys_clk_i(sys_clk), .reset_n_i(reset_n), .scl_i(scl), .sda_i(sda), .sda_o(dat),
    .sda_oe_o(oe), .analog_gain_i(analog_gain), .yuv_mode_i(yuv_mode),
    .band_gap_en_o(out_vec[28]), .band_gap_adj_o(out_vec[27:21]), .awb_scale_up_o(out_vec[20]),
    .rgb_median_en_o(out_vec[19]), .y_median_en_o(out_vec[18:16]),
    .chroma_delay_o(out_vec[15:14]), .preamp_boost_o(out_vec[13]), .half_current_o(out_vec[12]),
    .g_switch_rgb_uv_o(out_vec[11]), .g_switch_y_o(out_vec[10]), .red_gain_o(out_vec[9:5]),
    .blue_gain_o(out_vec[4:0]));
  serial_host_model u_host (.sys_clk_i(sys_clk), .dev_oe_i(oe), .dev_dat_i(dat), .scl_o(scl),
    .sda_o(sda));
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_errors++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic report_and_stop();
    $display("Checks %0d, errors %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  // Let input changes land before the one-clock output lag is sampled
  task automatic settle();
    repeat (2) @(posedge sys_clk);
    #1;
  endtask
  // Main sequence: table first, then the awkward cases
  initial begin
    repeat (3) @(posedge sys_clk);
    reset_n <= 1'b1;
    repeat (4) @(posedge sys_clk);
    check(32'(out_vec), 32'(RST_VEC));
    u_host.read_reg(DEV, 8'h33, rd);
    check(32'(rd), 32'h08);
    foreach (rows[i]) begin
      u_host.write_reg(DEV, rows[i].addr, rows[i].wdata, nack);
      check(32'(nack), 32'h0);
      check(32'(out_vec), 32'(rows[i].outs));
      u_host.read_reg(DEV, rows[i].addr, rd);
      check(32'(rd), 32'(rows[i].rdata));
    end
    // Automatic luma filtering right at the gain threshold and just below it
    analog_gain <= THRESH;
    settle();
    check(32'(out_vec[18:16]), 32'h7);
    // Back onto a clock edge before driving again
    @(posedge sys_clk);
    analog_gain <= THRESH - 6'h01;
    settle();
    check(32'(out_vec[18:16]), 32'h5);
    u_host.write_reg(DEV, 8'h60, 8'h10, nack);
    check(32'(out_vec[10]), 32'h1);
    yuv_mode <= 1'b0;
    settle();
    check(32'(out_vec[10]), 32'h0);
    @(posedge sys_clk);
    yuv_mode <= 1'b1;
    // A foreign device address must be ignored and left unanswered
    u_host.write_reg(DEV ^ 7'h01, 8'h33, 8'h55, nack);
    check(32'(nack), 32'h1);
    check(32'(out_vec[27:21]), 32'h0);
    // Reset in mid-run restores every default
    @(posedge sys_clk);
    reset_n <= 1'b0;
    repeat (3) @(posedge sys_clk);
    #1;
    check(32'(out_vec), 32'(RST_VEC));
    @(posedge sys_clk);
    reset_n <= 1'b1;
    repeat (4) @(posedge sys_clk);
    u_host.read_reg(DEV, 8'h60, rd);
    check(32'(rd), 32'h00);
    report_and_stop();
  end
  // Watchdog well beyond the expected run length
  initial begin
    repeat (90000) @(posedge sys_clk);
    n_errors++;
    report_and_stop();
  end
endmodule
`default_nettype wire
